// ==== common/seb_pkg.sv ====
// Package: constants, states and carriers of the serial EEPROM bus slave
// ==========================================================================
package seb_pkg;

   // ==========================================================================
   // Geometry and protocol constants
   localparam int ADDR_W = 7;               // Byte address width
   localparam int PAGE_W = 4;               // Page offset width
   localparam int PAGE_N = 16;              // Bytes in the page buffer
   localparam int MEM_N = 128;              // Bytes in the array
   localparam logic [3:0] DEV_TYPE = 4'ha;  // Fixed slave address nibble
   localparam logic [3:0] LAST_BIT = 4'h7;  // Index of the eighth bit
   localparam logic [3:0] BYTE_BITS = 4'h8; // Bits in a byte
   localparam logic [2:0] PIN_RST = 3'h7;   // Idle pins read high

   // ==========================================================================
   // Timing
   localparam longint CLK_HZ = 50000000;    // System clock rate
   localparam longint T_WR_MS = 10;         // Longest write cycle, ms
   localparam int WR_CYC = int'((T_WR_MS * CLK_HZ) / 1000); // Rounded down
   localparam int WCNT_W = 20;              // Write timer width

   // ==========================================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_WORD, ST_DATA, ST_ACK, ST_SEND, ST_MACK, ST_WAIT
   } seb_st_e;

   // Pins as seen by the synchroniser
   typedef struct packed {
      logic scl;
      logic sda;
      logic aux;
   } seb_pins_s;

   // Synchroniser state: three stages and the accepted level
   typedef struct packed {
      seb_pins_s ff1;
      seb_pins_s ff2;
      seb_pins_s ff3;
      seb_pins_s lvl;
   } seb_sync_s;

   // Main engine state
   typedef struct packed {
      seb_st_e st;                 // Protocol state
      seb_st_e nxt;                // State after the acknowledge slot
      logic scl_q;                 // Previous filtered SCL
      logic sda_q;                 // Previous filtered SDA
      logic bidir;                 // Bidirectional mode entered
      logic busy;                  // Self-timed write running
      logic [WCNT_W-1:0] wcnt;     // Write cycle countdown
      logic [7:0] sh;              // Shift register
      logic [3:0] cnt;             // Bit counter
      logic [ADDR_W-1:0] ptr;      // Address pointer
      logic dirty;                 // Page buffer holds data
      logic wp_seen;               // Aux pin low during a write
      logic mack;                  // Master acknowledged
      logic sda_oe;                // Pull SDA low
      logic sda_drv;               // Driven level, always low
   } seb_state_s;

endpackage : seb_pkg

// ==== hdl/seb_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module seb_sync (
   input wire logic clock,
   input wire logic srst,
   input wire seb_pkg::seb_pins_s pins_in,
   output seb_pkg::seb_pins_s pins_lvl
);

   // ==========================================================================
   // State
   seb_pkg::seb_sync_s state_reg; // Registered stages
   seb_pkg::seb_sync_s state_next; // Next stages

   // ==========================================================================
   // Next state: a level is accepted only when stages two and three agree,
   // which also rejects single-sample glitches on the slow bus lines
   always_comb begin
      state_next = state_reg;
      state_next.ff1 = pins_in;
      state_next.ff2 = state_reg.ff1;
      state_next.ff3 = state_reg.ff2;
      for (int i = 0; i < 3; i++) begin
         // Per pin agreement
         if (state_reg.ff2[i] == state_reg.ff3[i]) begin
            state_next.lvl[i] = state_reg.ff3[i];
         end
      end
   end

   // Register the stages
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= {4{seb_pkg::PIN_RST}};
      end else begin
         state_reg <= state_next;
      end
   end

   assign pins_lvl = state_reg.lvl;

endmodule : seb_sync

// ==== hdl/seb_mem.sv ====
// Byte array with sixteen-entry page buffer
`timescale 1ns/1ps
module seb_mem (
   input wire logic clock,
   input wire logic srst,
   input wire logic [seb_pkg::ADDR_W-1:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic buf_we,
   input wire logic [seb_pkg::PAGE_W-1:0] buf_idx,
   input wire logic [7:0] buf_data,
   input wire logic buf_clr,
   input wire logic commit,
   input wire logic [seb_pkg::ADDR_W-seb_pkg::PAGE_W-1:0] page
);

   // ==========================================================================
   // Storage: the array is not reset, it models nonvolatile cells
   logic [7:0] mem [seb_pkg::MEM_N]; // Cell array
   logic [7:0] pbuf [seb_pkg::PAGE_N]; // Page buffer
   logic [seb_pkg::PAGE_N-1:0] pval; // Buffer entry written

   // ==========================================================================
   // Buffer, commit and read; a rewrite of one entry replaces it
   always_ff @(posedge clock) begin
      rd_data <= mem[rd_addr];
      if (srst) begin
         pval <= '0;
      end else if (commit) begin
         // All buffered bytes land in one program cycle
         for (int i = 0; i < seb_pkg::PAGE_N; i++) begin
            if (pval[i]) begin
               mem[{page, i[seb_pkg::PAGE_W-1:0]}] <= pbuf[i];
            end
         end
         pval <= '0;
      end else if (buf_we) begin
         pbuf[buf_idx] <= buf_data;
         pval[buf_idx] <= 1'b1;
      end else if (buf_clr) begin
         pval <= '0;
      end
   end

endmodule : seb_mem

// ==== hdl/seb_slave.sv ====
// Two-wire bus slave front end of a 128-byte serial EEPROM
`timescale 1ns/1ps
module seb_slave #(
   parameter int WR_CYCLES = seb_pkg::WR_CYC // Write cycle length in clocks
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic aux_clock_write_enable_pin,
   output logic sda_out,
   output logic sda_oe,
   output logic write_busy,
   output logic bidir_mode
);

   // ==========================================================================
   // Pin synchronisation
   // Nothing here is clocked by SCL.
   // Each pin is seen about four clocks late;
   // SDA and SCL share that delay, so their
   // order on the pins survives the filter.
   // SDA answers one clock after the filtered
   // SCL fall, some 4.5 clocks after the pin.
   // Limitation: the master's SCL low time
   // must exceed that, or our own SDA move
   // lands with SCL high and reads as a
   // START or STOP.
   // The aux pin is a write permission only;
   // its edges are never counted.
   // No registers: the pins are the interface.
   // The array commits at the STOP; the busy
   // timer only models the deaf time after.
   seb_pkg::seb_pins_s pins_raw; // Raw pin bundle
   seb_pkg::seb_pins_s pins; // Filtered levels

   // Bundle the asynchronous pins
   assign pins_raw = '{scl: scl_in, sda: sda_in, aux: aux_clock_write_enable_pin};

   // Resets to the idle high level
   seb_sync u_sync (
      .clock(clock),
      .srst(srst),
      .pins_in(pins_raw),
      .pins_lvl(pins)
   );

   // ==========================================================================
   // State and memory hookup
   // The memory reads at the pointer each
   // clock, so the next read byte is ready
   // long before the fall that sends it.
   // Data reaches the array only by commit.
   seb_pkg::seb_state_s r_reg; // Engine state
   seb_pkg::seb_state_s r_next; // Engine next state
   logic [7:0] rd_data; // Byte at the pointer
   logic buf_we; // Store received byte
   logic buf_clr; // Drop buffered bytes
   logic commit; // Program the page

   seb_mem u_mem (
      .clock(clock),
      .srst(srst),
      .rd_addr(r_reg.ptr),
      .rd_data(rd_data),
      .buf_we(buf_we),
      .buf_idx(r_reg.ptr[seb_pkg::PAGE_W-1:0]),
      .buf_data(r_reg.sh),
      .buf_clr(buf_clr),
      .commit(commit),
      .page(r_reg.ptr[seb_pkg::ADDR_W-1:seb_pkg::PAGE_W])
   );

   // ==========================================================================
   // Bus events from the filtered levels
   // Edges compare with last clock's copy.
   // A condition needs SCL high twice, so an
   // SDA move at an SCL edge is never one.
   // A spike shorter than one clock is lost.
   logic scl_rise; // SCL low to high
   logic scl_fall; // SCL high to low
   logic start_ev; // START seen
   logic stop_ev; // STOP seen
   logic held_hi; // SCL high in both samples
   // Timer reload, cut to the timer width
   logic wr_cyc_ld; // Write timer reload
   logic [seb_pkg::WCNT_W-1:0] wr_load; // Timer load value

   assign wr_load = seb_pkg::WCNT_W'(WR_CYCLES);
   assign scl_rise = pins.scl & ~r_reg.scl_q;
   assign scl_fall = ~pins.scl & r_reg.scl_q;
   assign held_hi = pins.scl & r_reg.scl_q;
   // Any SDA move while SCL stays high is a condition, never data
   assign start_ev = held_hi & r_reg.sda_q & ~pins.sda;
   assign stop_ev = held_hi & ~r_reg.sda_q & pins.sda;

   // ==========================================================================
   // Protocol engine; SDA only moves just after an SCL fall
   // Priority within one clock:
   //    1. mode latch and write timer
   //    2. STOP, which may start programming
   //    3. START, repeated or not
   //    4. the byte engine of the state
   // A byte is eight SCL rises; the ack slot
   // opens at the eighth fall, ends at the ninth.
   // Only sda_oe reaches the bus; a released
   // line is left to the pull-up.
   // Byte write, in SCL periods: START,
   // address, ack, word, ack, data, ack, STOP.
   // A read turns the bus round after the
   // address ack; the master's ninth bit
   // decides what follows.
   always_comb begin
      r_next = r_reg;
      buf_we = 1'b0;
      buf_clr = 1'b0;
      commit = 1'b0;
      wr_cyc_ld = 1'b0;
      r_next.scl_q = pins.scl;
      r_next.sda_q = pins.sda;

      // Mode latch: first SCL fall leaves the bus-ignoring mode for good
      if (scl_fall) begin
         // Never cleared; only reset leaves it
         r_next.bidir = 1'b1;
      end

      // Self-timed write cycle countdown
      // The clock that sees one ends the run
      if (r_reg.busy) begin
         if (r_reg.wcnt <= 20'h00001) begin
            r_next.busy = 1'b0;
            r_next.wcnt = '0;
         end else begin
            r_next.wcnt = r_reg.wcnt - 20'h00001;
         end
      end

      // Aux pin low at any moment of a write marks it protected
      if (!pins.aux && r_reg.st != seb_pkg::ST_IDLE) begin
         // Held to the next START
         r_next.wp_seen = 1'b1;
      end

      if (!r_reg.bidir) begin
         // Bus ignored until bidirectional mode
         r_next.st = seb_pkg::ST_IDLE;
      end else if (stop_ev) begin
         // STOP ends any operation and may start programming
         r_next.st = seb_pkg::ST_IDLE;
         r_next.sda_oe = 1'b0;
         if (r_reg.dirty && !r_reg.wp_seen && pins.aux && !r_reg.busy) begin
            // A dummy write is not dirty
            commit = 1'b1;
            wr_cyc_ld = 1'b1;
         end
         r_next.dirty = 1'b0;
      end else if (start_ev) begin
         // START, repeated or not, restarts addressing
         r_next.st = seb_pkg::ST_DEV;
         r_next.cnt = '0;
         r_next.sda_oe = 1'b0;
         r_next.dirty = 1'b0;
         r_next.wp_seen = ~pins.aux;
         // Cut transfers leave nothing behind
         buf_clr = 1'b1;
      end else begin
         case (r_reg.st)
            seb_pkg::ST_DEV, seb_pkg::ST_WORD, seb_pkg::ST_DATA: begin
               // Receive a byte on rising edges
               if (scl_rise && r_reg.cnt != seb_pkg::BYTE_BITS) begin
                  r_next.sh = {r_reg.sh[6:0], pins.sda};
                  r_next.cnt = r_reg.cnt + 4'h1;
               end else if (scl_fall && r_reg.cnt == seb_pkg::BYTE_BITS) begin
                  r_next.cnt = '0;
                  r_next.st = seb_pkg::ST_ACK;
                  // Pull SDA low for the ack
                  r_next.sda_oe = 1'b1;
                  if (r_reg.st == seb_pkg::ST_DEV) begin
                     // Address byte: type nibble, three don't care, R/W
                     if (r_reg.sh[7:4] != seb_pkg::DEV_TYPE || r_reg.busy) begin
                        // Not ours, or still programming: stay silent
                        r_next.st = seb_pkg::ST_WAIT;
                        r_next.sda_oe = 1'b0;
                     end else if (r_reg.sh[0]) begin
                        // A read starts at the pointer
                        r_next.nxt = seb_pkg::ST_SEND;
                     end else begin
                        r_next.nxt = seb_pkg::ST_WORD;
                     end
                  end else if (r_reg.st == seb_pkg::ST_WORD) begin
                     // Byte address; top bit beyond the array is dropped
                     r_next.ptr = r_reg.sh[seb_pkg::ADDR_W-1:0];
                     r_next.nxt = seb_pkg::ST_DATA;
                  end else begin
                     // Data byte: buffer it, step only the page offset
                     // Index is the pointer before the step
                     buf_we = 1'b1;
                     r_next.dirty = 1'b1;
                     r_next.ptr[seb_pkg::PAGE_W-1:0] =
                        r_reg.ptr[seb_pkg::PAGE_W-1:0] + 4'h1;
                     r_next.nxt = seb_pkg::ST_DATA;
                  end
               end
            end
            seb_pkg::ST_ACK: begin
               // Acknowledge slot ends at the ninth falling edge
               if (scl_fall) begin
                  if (r_reg.nxt == seb_pkg::ST_SEND) begin
                     // First read byte goes out at once, MSB first
                     r_next.sh = rd_data;
                     r_next.sda_oe = ~rd_data[7];
                     r_next.cnt = '0;
                     r_next.st = seb_pkg::ST_SEND;
                  end else begin
                     r_next.sda_oe = 1'b0;
                     // Write side: next byte in
                     r_next.st = r_reg.nxt;
                  end
               end
            end
            seb_pkg::ST_SEND: begin
               // Shift a bit out on each falling edge
               if (scl_fall) begin
                  if (r_reg.cnt == seb_pkg::LAST_BIT) begin
                     // Release SDA for the master's acknowledge
                     r_next.sda_oe = 1'b0;
                     // Step across all address bits
                     r_next.ptr = r_reg.ptr + 7'h01;
                     r_next.st = seb_pkg::ST_MACK;
                  end else begin
                     // A one is shown by releasing
                     r_next.sh = {r_reg.sh[6:0], 1'b0};
                     r_next.sda_oe = ~r_reg.sh[6];
                     r_next.cnt = r_reg.cnt + 4'h1;
                  end
               end
            end
            seb_pkg::ST_MACK: begin
               // Sample the master acknowledge on the rising edge
               if (scl_rise) begin
                  // Low SDA: the master wants more
                  r_next.mack = ~pins.sda;
               end else if (scl_fall) begin
                  if (r_reg.mack) begin
                     // Acknowledged: next byte follows
                     r_next.sh = rd_data;
                     r_next.sda_oe = ~rd_data[7];
                     r_next.cnt = '0;
                     r_next.st = seb_pkg::ST_SEND;
                  end else begin
                     // No acknowledge: quiet until START or STOP
                     r_next.st = seb_pkg::ST_WAIT;
                  end
               end
            end
            seb_pkg::ST_WAIT: begin
               // Released; only START or STOP moves on
               // Foreign, busy or not acknowledged
               r_next.sda_oe = 1'b0;
            end
            default: begin
               // Idle: ignore everything but START
               // Also holds ST_IDLE itself
               r_next.st = seb_pkg::ST_IDLE;
               r_next.sda_oe = 1'b0;
            end
         endcase
      end

      // Programming starts with the STOP that closed the write
      if (wr_cyc_ld) begin
         // Last, so it beats the countdown
         r_next.busy = 1'b1;
         r_next.wcnt = wr_load;
      end
   end

   // ==========================================================================
   // State register
   // Edge copies start high, so the idle bus
   // after reset shows no false edge.
   // Memory contents are never reset.
   always_ff @(posedge clock) begin
      if (srst) begin
         r_reg <= '{st: seb_pkg::ST_IDLE, nxt: seb_pkg::ST_IDLE,
                    scl_q: 1'b1, sda_q: 1'b1, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================================
   // Outputs, all from the state register
   // sda_out is a constant low: the pin is
   // open drain and only sda_oe moves.
   // No output is a combinational path.
   assign sda_out = r_reg.sda_drv;
   assign sda_oe = r_reg.sda_oe;
   assign write_busy = r_reg.busy;
   assign bidir_mode = r_reg.bidir;

endmodule : seb_slave

// ==== verification/seb_slave_sva.sv ====
// Port-level concurrent checks of the serial EEPROM bus slave
`timescale 1ns/1ps
module seb_slave_sva #(
   parameter int WR_CYCLES = 200 // Write cycle length in clocks
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic aux_clock_write_enable_pin,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_busy,
   input wire logic bidir_mode
);
   // ==========================================================================
   // Helper: length of the current busy run, a counter since it spans many cycles
   int busy_cnt;
   always_ff @(posedge clock) begin
      if (srst || !write_busy) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // ==========================================================================
   // Assertions
   sda_low_only_a: assert property (sda_oe |-> !sda_out)
      else $error("Data pin driven high");
   oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
      else $error("Pull on data pin too short");
   mode_entry_a: assert property ($fell(scl_in) |-> ##[1:8] bidir_mode)
      else $error("Clock fall did not enter bus mode");
   mode_sticky_a: assert property (bidir_mode |=> bidir_mode)
      else $error("Bus mode left");
   oe_needs_mode_a: assert property (sda_oe |-> bidir_mode)
      else $error("Data pulled before bus mode");
   busy_no_ack_a: assert property (write_busy |-> !sda_oe)
      else $error("Answer while programming");
   busy_length_a: assert property ($fell(write_busy) |-> busy_cnt == WR_CYCLES)
      else $error("Write cycle length wrong");
   busy_bound_a: assert property (busy_cnt <= WR_CYCLES)
      else $error("Write cycle overran");
   protect_hold_a: assert property ($rose(write_busy) |-> $past(aux_clock_write_enable_pin, 4))
      else $error("Programming while protected");
   stop_idle_a: assert property ($rose(write_busy) |-> scl_in && sda_in)
      else $error("Programming began without a stop");
   // Main scenarios reached
   cover property ($rose(write_busy));
   cover property ($fell(write_busy));
   cover property ($rose(bidir_mode));
endmodule : seb_slave_sva

bind seb_slave seb_slave_sva #(.WR_CYCLES(WR_CYCLES)) seb_slave_sva_inst (
   .clock(clock), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
   .aux_clock_write_enable_pin(aux_clock_write_enable_pin), .sda_out(sda_out),
   .sda_oe(sda_oe), .write_busy(write_busy), .bidir_mode(bidir_mode)
);

// ==== verification/seb_master.sv ====
// Behavioural two-wire bus master that drives the slave's pins
`timescale 1ns/1ps
module seb_master (
   input wire logic clock,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_pull
);
   // ==========================================================================
   // Idle bus: clock stands high, data released to its pull-up
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Quarter of a 160 ns bus period
   task automatic qtr();
      repeat (2) @(negedge clock);
   endtask : qtr
   // Start, also repeated; data only falls while clock is high. The 120 ns
   // before the clock rises outlast the slave's late release of an acknowledge.
   task automatic start();
      qtr();
      sda_pull = 1'b0;
      repeat (2) qtr();
      scl = 1'b1;
      repeat (2) qtr();
      sda_pull = 1'b1;
      repeat (2) qtr();
      scl = 1'b0;
   endtask : start
   // Stop, then a free bus before any new start
   task automatic stop();
      qtr();
      sda_pull = 1'b1;
      repeat (2) qtr();
      scl = 1'b1;
      repeat (2) qtr();
      sda_pull = 1'b0;
      repeat (4) qtr();
   endtask : stop
   // One bit: data changes early in the low phase, sampled at the end of
   // the high phase; low lasts 120 ns so the slave's late answer settles
   task automatic bit_io(input logic b, output logic r);
      qtr();
      sda_pull = !b;
      repeat (2) qtr();
      scl = 1'b1;
      qtr();
      r = sda_wire;
      scl = 1'b0;
   endtask : bit_io
   // Byte out, MSB first; ack is high when the slave pulled the ninth bit
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : wbyte
   // Byte in; the ninth bit carries our ack or its absence
   task automatic rbyte(output logic [7:0] d, input logic give_ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(!give_ack, r);
   endtask : rbyte
endmodule : seb_master

// ==== verification/seb_slave_test.sv ====
// Self-checking bench for the serial EEPROM bus slave
`timescale 1ns/1ps
module seb_slave_test;
   // ==========================================================================
   // Short write cycle keeps the run brief
   localparam int WRC = 200;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic aux = 1'b1; // Writes allowed unless a test lowers it
   logic scl;
   logic sda_pull;
   logic sda_out;
   logic sda_oe;
   logic write_busy;
   logic bidir_mode;
   logic sda_wire;
   logic [7:0] exp_mem [128]; // Expected array contents
   logic [7:0] wq[$]; // Data bytes of the next write
   int n_errors = 0;
   int tests_run = 0;
   // Open drain wire with pull-up
   assign sda_wire = !(sda_oe && !sda_out) && !sda_pull;
   initial begin
      forever #10 clock = ~clock;
   end
   seb_slave #(.WR_CYCLES(WRC)) seb_slave_inst (
      .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
      .aux_clock_write_enable_pin(aux), .sda_out(sda_out), .sda_oe(sda_oe),
      .write_busy(write_busy), .bidir_mode(bidir_mode)
   );
   seb_master seb_master_inst (
      .clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull)
   );
   // ==========================================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic send_addr(input logic [7:0] a, input logic exp_ack);
      logic ack;
      seb_master_inst.start();
      seb_master_inst.wbyte(a, ack);
      check({7'h0, ack}, {7'h0, exp_ack});
   endtask : send_addr
   // Poll until acked; a bounded count so a stuck write cycle ends the run
   task automatic wait_ready();
      logic ack;
      for (int i = 0; i < 40; i++) begin
         seb_master_inst.start();
         seb_master_inst.wbyte(8'ha0, ack);
         seb_master_inst.stop();
         if (ack) return;
      end
      n_errors++;
      $display("ERROR at %0t: write cycle never ended", $time);
      report_and_stop();
   endtask : wait_ready
   // Write wq from word address wa; don't-care address bits set
   task automatic write_seq(input logic [7:0] wa);
      logic ack;
      send_addr(8'hae, 1'b1);
      seb_master_inst.wbyte(wa, ack);
      check({7'h0, ack}, 8'h01);
      foreach (wq[i]) begin
         seb_master_inst.wbyte(wq[i], ack);
         check({7'h0, ack}, 8'h01);
      end
      seb_master_inst.stop();
   endtask : write_seq
   // Read n bytes from a, acking all but the last
   task automatic rd_n(input logic [6:0] a0, input int n);
      logic [7:0] d;
      logic [6:0] a;
      a = a0;
      for (int i = 0; i < n; i++) begin
         seb_master_inst.rbyte(d, i < n - 1);
         check(d, exp_mem[a]);
         a = a + 7'h01;
      end
      repeat (6) @(negedge clock);
      check({7'h0, sda_oe}, 8'h00);
      seb_master_inst.stop();
   endtask : rd_n
   task automatic rd_sel(input logic [7:0] wa, input int n);
      logic ack;
      send_addr(8'hae, 1'b1);
      seb_master_inst.wbyte(wa, ack);
      check({7'h0, ack}, 8'h01);
      send_addr(8'ha3, 1'b1);
      rd_n(wa[6:0], n);
   endtask : rd_sel
   // ==========================================================================
   // Scenarios
   task automatic t_mode();
      logic r;
      check({6'h0, sda_oe, write_busy}, 8'h00);
      check({7'h0, bidir_mode}, 8'h00);
      seb_master_inst.bit_io(1'b1, r);
      seb_master_inst.stop();
      check({7'h0, bidir_mode}, 8'h01);
      $display("Test mode entry done");
   endtask : t_mode
   task automatic t_byte_poll();
      wq = {8'h5a};
      write_seq(8'h7f);
      exp_mem[127] = 8'h5a;
      repeat (4) @(negedge clock);
      check({7'h0, write_busy}, 8'h01);
      send_addr(8'ha0, 1'b0);
      seb_master_inst.stop();
      wait_ready();
      $display("Test byte write and polling done");
   endtask : t_byte_poll
   task automatic t_foreign();
      logic [7:0] bad [4] = '{8'h90, 8'hb0, 8'h2e, 8'he1};
      foreach (bad[i]) begin
         send_addr(bad[i], 1'b0);
         seb_master_inst.stop();
      end
      $display("Test foreign addresses done");
   endtask : t_foreign
   task automatic t_page();
      wq = {};
      for (int k = 0; k < 18; k++) begin
         wq.push_back(8'h30 + 8'(k));
         exp_mem[(14 + k) % 16] = 8'h30 + 8'(k);
      end
      write_seq(8'h0e);
      aux = 1'b0;
      wait_ready();
      aux = 1'b1;
      $display("Test page write done");
   endtask : t_page
   // Protected write, then reads with the pin still low
   task automatic t_protect_read();
      @(negedge clock);
      aux = 1'b0;
      wq = {8'hff};
      write_seq(8'h00);
      repeat (12) @(negedge clock);
      check({7'h0, write_busy}, 8'h00);
      rd_sel(8'h0e, 2);
      rd_sel(8'h7f, 3);
      send_addr(8'ha9, 1'b1);
      rd_n(7'h02, 1);
      aux = 1'b1;
      $display("Test protection and reads done");
   endtask : t_protect_read
   // ==========================================================================
   // Main sequence and hang guard
   initial begin
      repeat (6) @(negedge clock);
      srst = 1'b0;
      repeat (4) @(negedge clock);
      t_mode();
      t_byte_poll();
      t_foreign();
      t_page();
      t_protect_read();
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge clock);
      n_errors++;
      $display("ERROR at %0t: run limit reached", $time);
      report_and_stop();
   end
endmodule : seb_slave_test
